/* File: design/sfrb_pkg.sv */
// constants for the bank-one special register map: indices, masks, reset values
// assumes a 32-bit apb master; each register is one word at byte address 4 * index
package sfrb_pkg;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [7:0] IDX_INDIRECT = 8'h80;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_PC_LOW = 8'h82;
  localparam logic [7:0] IDX_STATUS = 8'h83;
  localparam logic [7:0] IDX_POINTER = 8'h84;
  localparam logic [7:0] IDX_DIR_A = 8'h85;
  localparam logic [7:0] IDX_DIR_B = 8'h86;
  localparam logic [7:0] IDX_DIR_C = 8'h87;
  localparam logic [7:0] IDX_PC_LATCH = 8'h8A;
  localparam logic [7:0] IDX_INT_CTRL = 8'h8B;
  localparam logic [7:0] IDX_PERIPH_IE = 8'h8C;
  localparam logic [7:0] IDX_POWER = 8'h8E;
  localparam logic [7:0] IDX_T2_PERIOD = 8'h92;
  localparam logic [7:0] IDX_SSP_ADDR = 8'h93;
  localparam logic [7:0] IDX_SSP_STAT = 8'h94;
  localparam logic [7:0] IDX_CONV_CFG = 8'h9F;
  localparam logic [7:0] BANK_ONE_BASE = 8'h80;
  localparam int OFFSET_W = 5;

  // ****************************************
  // mirrored core locations in bank zero
  // ****************************************
  localparam logic [7:0] MIR_INDIRECT = 8'h00;
  localparam logic [7:0] MIR_PC_LOW = 8'h02;
  localparam logic [7:0] MIR_STATUS = 8'h03;
  localparam logic [7:0] MIR_POINTER = 8'h04;
  localparam logic [7:0] MIR_PC_LATCH = 8'h0A;
  localparam logic [7:0] MIR_INT_CTRL = 8'h0B;

  // ****************************************
  // field positions and masks
  // ****************************************
  localparam int ST_BANK_LOW = 5;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_POWERDOWN = 3;
  localparam logic [7:0] PERIPH_IE_MASK = 8'h4F;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_DIR_A = 8'h3F;
  localparam logic [7:0] MASK_PC_LATCH = 8'h1F;
  localparam logic [7:0] MASK_POWER = 8'h03;
  localparam logic [7:0] MASK_SSP_STAT = 8'h3F;
  localparam logic [7:0] MASK_CONV_CFG = 8'h07;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam logic [7:0] RST_STATUS_COLD = 8'h18;
  localparam logic [5:0] RST_DIR_A = 6'h3F;
  localparam logic [7:0] RST_DIR_B = 8'hFF;
  localparam logic [7:0] RST_DIR_C = 8'hFF;
  localparam logic [7:0] RST_T2_PERIOD = 8'hFF;
  localparam logic [7:0] RST_ZERO8 = 8'h00;
  localparam logic [2:0] RST_CONV_CFG = 3'h0;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] option;
    logic [7:0] pcLow;
    logic [4:0] pcHigh;
    logic [7:0] status;
    logic [7:0] pointer;
    logic [5:0] dirA;
    logic [7:0] dirB;
    logic [7:0] dirC;
    logic [4:0] pcLatch;
    logic [7:0] intCtrl;
    logic [7:0] periphIe;
    logic [1:0] power;
    logic [7:0] t2Period;
    logic [7:0] sspAddr;
    logic [5:0] serial_port_status;
    logic [2:0] convCfg;
  } sfrb_state_t;

endpackage

/* File: design/sfrb_power_flags.sv */
// next value of the power-on and brown-out flags of the power status register
// assumes cause inputs are stable while the synchronous reset is held
`timescale 1ns/1ps
module sfrb_power_flags (
  input wire logic resetActive, // reset is being applied this cycle
  input wire logic powerOnCause, // reset is a power-on reset
  input wire logic brownOutCause, // reset is a brown-out reset
  input wire logic writeEn, // software write to the power status register
  input wire logic [1:0] writeData, // written flag values
  input wire logic [1:0] flagsNow, // current {power-on flag, brown-out flag}
  output logic [1:0] flagsNext // next flag values
);

  // flags are active low: a cleared bit marks the cause; software sets them to arm detection
  always_comb begin
    flagsNext = flagsNow;
    if (resetActive) begin
      if (powerOnCause) begin
        flagsNext = {1'b0, ~brownOutCause};
      end else if (brownOutCause) begin
        flagsNext = {flagsNow[1], 1'b0};
      end
    end else if (writeEn) begin
      flagsNext = writeData;
    end
  end

endmodule

/* File: design/sfrb_bank1_regs.sv */
// bank-one special register map of a small 8-bit controller, as an apb slave
// assumes an apb master on clk; reset causes are levels valid while rstn is low
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module sfrb_bank1_regs (
  input wire logic clk, // core clock, 100 MHz
  input wire logic rstn, // synchronous reset, active low
  input wire logic powerOnReset, // reset cause is power-on
  input wire logic brownOutReset, // reset cause is brown-out
  input wire logic watchdogReset, // reset cause is watchdog timeout
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction, high for write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb write strobes
  input wire logic [5:0] sspFlags, // serial port status from the port logic
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, always low
  output logic [7:0] optionOut, // option register
  output logic [7:0] pcLowOut, // program counter low byte
  output logic [4:0] pcHighOut, // program counter upper bits 12 to 8
  output logic [7:0] statusOut, // core status
  output logic [7:0] pointerOut, // indirect pointer
  output logic [5:0] dirAOut, // port a direction, one is input
  output logic [7:0] dirBOut, // port b direction
  output logic [7:0] dirCOut, // port c direction
  output logic [7:0] intCtrlOut, // interrupt control
  output logic [7:0] periphIeOut, // peripheral interrupt enables
  output logic [1:0] powerFlagsOut, // {power-on flag, brown-out flag}
  output logic [7:0] t2PeriodOut, // timer two period
  output logic [7:0] sspAddrOut // serial port slave address
);

  // ****************************************
  // state
  // ****************************************
  sfrb_pkg::sfrb_state_t state_reg;
  sfrb_pkg::sfrb_state_t state_next;
  logic [7:0] reqIndex;
  logic [7:0] target;
  logic addrInRange;
  logic setupPhase;
  logic writeTaken;
  logic powerWrite;
  logic [7:0] wrByte;
  logic [1:0] powerNext;

  // ****************************************
  // address mapping
  // ****************************************
  // bank-zero core locations that share storage with their bank-one twins
  function automatic logic isCoreMirror(input logic [7:0] idx);
    logic hit;
    hit = 1'b0;
    if (idx == sfrb_pkg::MIR_INDIRECT) begin
      hit = 1'b1;
    end else if (idx == sfrb_pkg::MIR_PC_LOW) begin
      hit = 1'b1;
    end else if (idx == sfrb_pkg::MIR_STATUS) begin
      hit = 1'b1;
    end else if (idx == sfrb_pkg::MIR_POINTER) begin
      hit = 1'b1;
    end else if (idx == sfrb_pkg::MIR_PC_LATCH) begin
      hit = 1'b1;
    end else if (idx == sfrb_pkg::MIR_INT_CTRL) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // folds bank-zero mirrors and bank-one direct offsets onto one canonical index
  function automatic logic [7:0] canonIndex(input logic [7:0] idx, input logic bankLow);
    logic [7:0] r;
    r = idx;
    if (idx[7] == 1'b0 && bankLow) begin
      r = sfrb_pkg::BANK_ONE_BASE | {3'h0, idx[sfrb_pkg::OFFSET_W-1:0]};
    end else if (isCoreMirror(idx)) begin
      r = sfrb_pkg::BANK_ONE_BASE | idx;
    end
    return r;
  endfunction

  // implemented bits per canonical location; reads and writes both pass through it
  function automatic logic [7:0] implMask(input logic [7:0] idx);
    logic [7:0] m;
    m = 8'h00;
    if (idx == sfrb_pkg::IDX_OPTION) begin
      m = sfrb_pkg::MASK_FULL;
    end else if (idx == sfrb_pkg::IDX_PC_LOW) begin
      m = sfrb_pkg::MASK_FULL;
    end else if (idx == sfrb_pkg::IDX_STATUS) begin
      m = sfrb_pkg::MASK_FULL;
    end else if (idx == sfrb_pkg::IDX_POINTER) begin
      m = sfrb_pkg::MASK_FULL;
    end else if (idx == sfrb_pkg::IDX_DIR_A) begin
      m = sfrb_pkg::MASK_DIR_A;
    end else if (idx == sfrb_pkg::IDX_DIR_B) begin
      m = sfrb_pkg::MASK_FULL;
    end else if (idx == sfrb_pkg::IDX_DIR_C) begin
      m = sfrb_pkg::MASK_FULL;
    end else if (idx == sfrb_pkg::IDX_PC_LATCH) begin
      m = sfrb_pkg::MASK_PC_LATCH;
    end else if (idx == sfrb_pkg::IDX_INT_CTRL) begin
      m = sfrb_pkg::MASK_FULL;
    end else if (idx == sfrb_pkg::IDX_PERIPH_IE) begin
      m = sfrb_pkg::PERIPH_IE_MASK;
    end else if (idx == sfrb_pkg::IDX_POWER) begin
      m = sfrb_pkg::MASK_POWER;
    end else if (idx == sfrb_pkg::IDX_T2_PERIOD) begin
      m = sfrb_pkg::MASK_FULL;
    end else if (idx == sfrb_pkg::IDX_SSP_ADDR) begin
      m = sfrb_pkg::MASK_FULL;
    end else if (idx == sfrb_pkg::IDX_SSP_STAT) begin
      m = sfrb_pkg::MASK_SSP_STAT;
    end else if (idx == sfrb_pkg::IDX_CONV_CFG) begin
      m = sfrb_pkg::MASK_CONV_CFG;
    end
    return m;
  endfunction

  // read value of one canonical location; anything not listed is zero
  function automatic logic [7:0] readReg(input sfrb_pkg::sfrb_state_t s, input logic [7:0] idx);
    logic [7:0] r;
    r = 8'h00;
    if (idx == sfrb_pkg::IDX_OPTION) begin
      r = s.option;
    end else if (idx == sfrb_pkg::IDX_PC_LOW) begin
      r = s.pcLow;
    end else if (idx == sfrb_pkg::IDX_STATUS) begin
      r = s.status;
    end else if (idx == sfrb_pkg::IDX_POINTER) begin
      r = s.pointer;
    end else if (idx == sfrb_pkg::IDX_DIR_A) begin
      r = {2'h0, s.dirA};
    end else if (idx == sfrb_pkg::IDX_DIR_B) begin
      r = s.dirB;
    end else if (idx == sfrb_pkg::IDX_DIR_C) begin
      r = s.dirC;
    end else if (idx == sfrb_pkg::IDX_PC_LATCH) begin
      r = {3'h0, s.pcLatch};
    end else if (idx == sfrb_pkg::IDX_INT_CTRL) begin
      r = s.intCtrl;
    end else if (idx == sfrb_pkg::IDX_PERIPH_IE) begin
      r = s.periphIe & sfrb_pkg::PERIPH_IE_MASK;
    end else if (idx == sfrb_pkg::IDX_POWER) begin
      r = {6'h00, s.power};
    end else if (idx == sfrb_pkg::IDX_T2_PERIOD) begin
      r = s.t2Period;
    end else if (idx == sfrb_pkg::IDX_SSP_ADDR) begin
      r = s.sspAddr;
    end else if (idx == sfrb_pkg::IDX_SSP_STAT) begin
      r = {2'h0, s.serial_port_status};
    end else if (idx == sfrb_pkg::IDX_CONV_CFG) begin
      r = {5'h00, s.convCfg};
    end
    r = r & implMask(idx);
    return r;
  endfunction

  // ****************************************
  // request decode
  // ****************************************
  always_comb begin
    reqIndex = paddr[9:2];
    addrInRange = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    target = canonIndex(reqIndex, state_reg.status[sfrb_pkg::ST_BANK_LOW]);
    // the indirect location is not storage: it follows the pointer; a pointer
    // back at itself reads zero and drops writes
    if (target == sfrb_pkg::IDX_INDIRECT) begin
      target = canonIndex(state_reg.pointer, 1'b0);
      if (target == sfrb_pkg::IDX_INDIRECT) begin
        target = 8'h00;
      end
    end
    if (!addrInRange) begin
      target = 8'h00;
    end
    setupPhase = psel && !penable;
    writeTaken = psel && penable && state_reg.pready && pwrite && pstrb[0];
    // unimplemented bits never reach storage, so they cannot leak back on a read
    wrByte = pwdata[7:0] & implMask(target);
    powerWrite = writeTaken && (target == sfrb_pkg::IDX_POWER);
  end

  sfrb_power_flags u_power_flags (
    .resetActive(!rstn),
    .powerOnCause(powerOnReset),
    .brownOutCause(brownOutReset),
    .writeEn(powerWrite),
    .writeData(wrByte[1:0]),
    .flagsNow(state_reg.power),
    .flagsNext(powerNext)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    state_next.serial_port_status = sspFlags;
    state_next.power = powerNext;
    // one wait-free answer: data is latched in setup, ready shows in the first access cycle
    if (setupPhase) begin
      state_next.pready = 1'b1;
      state_next.prdata = {24'h000000, readReg(state_reg, target)};
    end
    if (writeTaken) begin
      if (target == sfrb_pkg::IDX_OPTION) begin
        state_next.option = wrByte;
      end else if (target == sfrb_pkg::IDX_PC_LOW) begin
        state_next.pcLow = wrByte;
        state_next.pcHigh = state_reg.pcLatch;
      end else if (target == sfrb_pkg::IDX_STATUS) begin
        // timeout and power-down bits are owned by the reset logic
        state_next.status = {wrByte[7:5], state_reg.status[4:3], wrByte[2:0]};
      end else if (target == sfrb_pkg::IDX_POINTER) begin
        state_next.pointer = wrByte;
      end else if (target == sfrb_pkg::IDX_DIR_A) begin
        state_next.dirA = wrByte[5:0];
      end else if (target == sfrb_pkg::IDX_DIR_B) begin
        state_next.dirB = wrByte;
      end else if (target == sfrb_pkg::IDX_DIR_C) begin
        state_next.dirC = wrByte;
      end else if (target == sfrb_pkg::IDX_PC_LATCH) begin
        state_next.pcLatch = wrByte[4:0];
      end else if (target == sfrb_pkg::IDX_INT_CTRL) begin
        state_next.intCtrl = wrByte;
      end else if (target == sfrb_pkg::IDX_PERIPH_IE) begin
        state_next.periphIe = wrByte & sfrb_pkg::PERIPH_IE_MASK;
      end else if (target == sfrb_pkg::IDX_T2_PERIOD) begin
        state_next.t2Period = wrByte;
      end else if (target == sfrb_pkg::IDX_SSP_ADDR) begin
        state_next.sspAddr = wrByte;
      end else if (target == sfrb_pkg::IDX_CONV_CFG) begin
        state_next.convCfg = wrByte[2:0];
      end
    end
    // ****************************************
    // reset columns
    // ****************************************
    if (!rstn) begin
      state_next.prdata = 32'h00000000;
      state_next.pready = 1'b0;
      state_next.serial_port_status = 6'h00;
      state_next.option = sfrb_pkg::RST_OPTION;
      state_next.pcLow = sfrb_pkg::RST_ZERO8;
      state_next.pcHigh = 5'h00;
      state_next.dirA = sfrb_pkg::RST_DIR_A;
      state_next.dirB = sfrb_pkg::RST_DIR_B;
      state_next.dirC = sfrb_pkg::RST_DIR_C;
      state_next.pcLatch = 5'h00;
      state_next.intCtrl = {7'h00, state_reg.intCtrl[0]};
      state_next.periphIe = sfrb_pkg::RST_ZERO8;
      state_next.t2Period = sfrb_pkg::RST_T2_PERIOD;
      state_next.sspAddr = sfrb_pkg::RST_ZERO8;
      state_next.convCfg = sfrb_pkg::RST_CONV_CFG;
      if (powerOnReset || brownOutReset) begin
        // unknown fields of the cold column are given zero so nothing starts undefined
        state_next.status = sfrb_pkg::RST_STATUS_COLD;
        state_next.pointer = sfrb_pkg::RST_ZERO8;
        state_next.intCtrl = sfrb_pkg::RST_ZERO8;
      end else begin
        // warm column: bank selects clear, arithmetic flags and pointer kept
        state_next.status = {3'h0, state_reg.status[4:0]};
        if (watchdogReset) begin
          state_next.status[sfrb_pkg::ST_TIMEOUT] = 1'b0;
          state_next.status[sfrb_pkg::ST_POWERDOWN] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign optionOut = state_reg.option;
  assign pcLowOut = state_reg.pcLow;
  assign pcHighOut = state_reg.pcHigh;
  assign statusOut = state_reg.status;
  assign pointerOut = state_reg.pointer;
  assign dirAOut = state_reg.dirA;
  assign dirBOut = state_reg.dirB;
  assign dirCOut = state_reg.dirC;
  assign intCtrlOut = state_reg.intCtrl;
  assign periphIeOut = state_reg.periphIe;
  assign powerFlagsOut = state_reg.power;
  assign t2PeriodOut = state_reg.t2Period;
  assign sspAddrOut = state_reg.sspAddr;

endmodule

/* File: testbench/sfrb_bank1_regs_assertions.sv */
// checker for the bank-one register map: apb answer timing, reset values, flags
// assumes it is bound to sfrb_bank1_regs and sees only that module's ports
`timescale 1ns/1ps
module sfrb_bank1_regs_assertions (
  input wire logic clk, // clock
  input wire logic rstn, // reset, active low
  input wire logic powerOnReset, // cold cause
  input wire logic brownOutReset, // cold cause
  input wire logic watchdogReset, // warm cause
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [11:0] paddr, // apb
  input wire logic [31:0] prdata, // apb
  input wire logic pready, // apb
  input wire logic pslverr, // apb
  input wire logic [7:0] optionOut, // option
  input wire logic [4:0] pcHighOut, // pc upper bits
  input wire logic [7:0] statusOut, // status
  input wire logic [5:0] dirAOut, // port a direction
  input wire logic [7:0] dirBOut, // port b direction
  input wire logic [7:0] dirCOut, // port c direction
  input wire logic [1:0] powerFlagsOut, // power flags
  input wire logic [7:0] t2PeriodOut // timer period
);
  // ****************************************
  // helper: flags as they stood before a reset
  // ****************************************
  logic [1:0] flagsSeen;
  always_ff @(posedge clk) begin
    if (rstn) begin
      flagsSeen <= powerFlagsOut;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  a_ready_after_setup: assert property (psel && !penable |=> pready && !pslverr)
    else $error("no ready one cycle after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_unmapped_zero: assert property (
    psel && !penable && (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0) |=> prdata == 32'h0)
    else $error("unmapped address read not zero");
  a_upper_bits_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("unused read bits not zero");
  a_reset_ones: assert property (
    $rose(rstn) |-> optionOut == 8'hFF && dirAOut == 6'h3F
    && dirBOut == 8'hFF && dirCOut == 8'hFF && t2PeriodOut == 8'hFF)
    else $error("reset value of direction, option or period wrong");
  a_pc_high_hold: assert property (!(psel && penable && pwrite) |=> $stable(pcHighOut))
    else $error("pc upper bits changed without a write");
  a_power_cold: assert property (
    $rose(rstn) && $past(powerOnReset) |-> powerFlagsOut == {1'b0, !$past(brownOutReset)})
    else $error("power flags wrong after power-on reset");
  a_power_warm: assert property (
    $rose(rstn) && !$past(powerOnReset) && !$past(brownOutReset) |-> powerFlagsOut == flagsSeen)
    else $error("power flags changed by warm reset");
  a_watchdog_status: assert property (
    $rose(rstn) && $past(watchdogReset) && !$past(powerOnReset)
    && !$past(brownOutReset) |-> statusOut[4:3] == 2'h1)
    else $error("status timeout bits wrong after watchdog reset");
endmodule

bind sfrb_bank1_regs sfrb_bank1_regs_assertions u_assert (.clk(clk), .rstn(rstn),
  .powerOnReset(powerOnReset), .brownOutReset(brownOutReset), .watchdogReset(watchdogReset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .optionOut(optionOut), .pcHighOut(pcHighOut), .statusOut(statusOut),
  .dirAOut(dirAOut), .dirBOut(dirBOut), .dirCOut(dirCOut), .powerFlagsOut(powerFlagsOut),
  .t2PeriodOut(t2PeriodOut));

/* File: testbench/sfrb_bank1_regs_tb.sv */
// self-checking bench for the bank-one register map, driven over apb
// assumes the checker is bound separately; byte address is four times the index
`timescale 1ns/1ps
module sfrb_bank1_regs_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic powerOnReset = 1'b1;
  logic brownOutReset = 1'b0;
  logic watchdogReset = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [5:0] sspFlags = 6'h00;
  logic [31:0] prdata, rd;
  logic pready, pslverr;
  logic [7:0] optionOut, pcLowOut, statusOut, pointerOut, dirBOut, dirCOut, intCtrlOut;
  logic [7:0] periphIeOut, t2PeriodOut, sspAddrOut;
  logic [4:0] pcHighOut;
  logic [5:0] dirAOut;
  logic [1:0] powerFlagsOut;
  int nFail = 0;
  int samplesChecked = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  sfrb_bank1_regs dut (.clk(clk), .rstn(rstn), .powerOnReset(powerOnReset), .brownOutReset(brownOutReset),
    .watchdogReset(watchdogReset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .sspFlags(sspFlags), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .optionOut(optionOut), .pcLowOut(pcLowOut), .pcHighOut(pcHighOut),
    .statusOut(statusOut), .pointerOut(pointerOut), .dirAOut(dirAOut), .dirBOut(dirBOut),
    .dirCOut(dirCOut), .intCtrlOut(intCtrlOut), .periphIeOut(periphIeOut), .powerFlagsOut(powerFlagsOut),
    .t2PeriodOut(t2PeriodOut), .sspAddrOut(sspAddrOut));

  // ****************************************
  // bus tasks and comparison
  // ****************************************
  task automatic finalReport();
    if (nFail == 0 && samplesChecked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      nFail++;
      finalReport();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // request is held until pready is seen high at a rising edge
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    chk(n, 32'h1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    xfer(1'b1, ba(i), d);
  endtask

  task automatic rdchk(input logic [7:0] i, input logic [7:0] e);
    xfer(1'b0, ba(i), 8'h00);
    chk(rd, {24'h0, e});
  endtask

  // causes are held for the whole reset and dropped with it
  task automatic hitReset(input logic po, input logic bo, input logic wd, input int n);
    @(posedge clk);
    rstn <= 1'b0;
    powerOnReset <= po;
    brownOutReset <= bo;
    watchdogReset <= wd;
    repeat (n) @(posedge clk);
    rstn <= 1'b1;
    powerOnReset <= 1'b0;
    brownOutReset <= 1'b0;
    watchdogReset <= 1'b0;
  endtask

  function automatic logic [7:0] coldVal(input logic [7:0] i);
    case (i)
      8'h81, 8'h86, 8'h87, 8'h92: return 8'hFF;
      8'h83: return 8'h18;
      8'h85: return 8'h3F;
      8'h8E: return 8'h01;
      default: return 8'h00;
    endcase
  endfunction

  // read-back after writing all ones: only implemented bits survive
  function automatic logic [7:0] onesVal(input logic [7:0] i);
    case (i)
      8'h81, 8'h82, 8'h86, 8'h87, 8'h8B, 8'h92, 8'h93: return 8'hFF;
      8'h85: return 8'h3F;
      8'h8A: return 8'h1F;
      8'h8C: return 8'h4F;
      8'h8E: return 8'h03;
      8'h9F: return 8'h07;
      default: return 8'h00;
    endcase
  endfunction

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    hitReset(1'b1, 1'b0, 1'b0, 20);
    for (int i = 8'h80; i <= 8'h9F; i++) begin
      rdchk(i[7:0], coldVal(i[7:0]));
    end
    for (int i = 8'h81; i <= 8'h9F; i++) begin
      if (i != 8'h83 && i != 8'h84 && i != 8'h94) begin
        wr(i[7:0], 8'hFF);
        rdchk(i[7:0], onesVal(i[7:0]));
      end
    end
    // the latch was filled after the last pc low write, so the upper bits must not move
    chk({27'h0, pcHighOut}, 32'h0);
    chk({24'h0, pcLowOut}, 32'hFF);
    chk({24'h0, intCtrlOut}, 32'hFF);
    chk({24'h0, periphIeOut}, 32'h4F);
    chk({24'h0, sspAddrOut}, 32'hFF);
    wr(8'h0A, 8'h15);
    rdchk(8'h8A, 8'h15);
    wr(8'h02, 8'h3C);
    rdchk(8'h82, 8'h3C);
    chk({27'h0, pcHighOut}, 32'h15);
    wr(8'h8B, 8'hA5);
    rdchk(8'h0B, 8'hA5);
    wr(8'h04, 8'h85);
    rdchk(8'h80, 8'h3F);
    chk({24'h0, pointerOut}, 32'h85);
    wr(8'h00, 8'h12);
    // a write lands at the access edge; the pin is looked at one edge later
    @(posedge clk);
    chk({26'h0, dirAOut}, 32'h12);
    rdchk(8'h05, 8'h00);
    wr(8'h83, 8'h27);
    rdchk(8'h03, 8'h3F);
    rdchk(8'h05, 8'h12);
    rdchk(8'h0C, 8'h4F);
    wr(8'h03, 8'h00);
    @(posedge clk);
    chk({24'h0, statusOut}, 32'h18);
    xfer(1'b1, 12'h618, 8'h00);
    xfer(1'b0, 12'h219, 8'h00);
    chk(rd, 32'h0);
    chk({24'h0, dirBOut}, 32'hFF);
    pstrb <= 4'hE;
    wr(8'h92, 8'h00);
    pstrb <= 4'hF;
    @(posedge clk);
    chk({24'h0, t2PeriodOut}, 32'hFF);
    sspFlags <= 6'h2A;
    wr(8'h94, 8'h00);
    rdchk(8'h94, 8'h2A);
    wr(8'h81, 8'h00);
    wr(8'h8E, 8'h02);
    hitReset(1'b0, 1'b0, 1'b1, 3);
    rdchk(8'h8E, 8'h02);
    rdchk(8'h83, 8'h08);
    rdchk(8'h84, 8'h85);
    chk({24'h0, optionOut}, 32'hFF);
    wr(8'h81, 8'h00);
    wr(8'h03, 8'h05);
    // master clear keeps the timeout, power-down and arithmetic bits
    hitReset(1'b0, 1'b0, 1'b0, 2);
    rdchk(8'h83, 8'h0D);
    chk({24'h0, optionOut}, 32'hFF);
    wr(8'h8E, 8'h03);
    hitReset(1'b0, 1'b1, 1'b0, 3);
    rdchk(8'h8E, 8'h02);
    rdchk(8'h84, 8'h00);
    finalReport();
  end
endmodule
